// ==== dsa_dbg_model.sv ====
// Purpose: debugger side of the system access register port
// Assumes: one request in flight, answer one cycle after it is taken
// Notes: drives 1 ns after the rising edge and samples after the answer edge
`timescale 1ns/100ps
module dsa_dbg_model import dsa_pkg::*; (
	// clock
	input wire logic sys_clk_i,
	// register access towards the device
	output logic reg_req_o,
	output dsa_reg_req_t reg_cmd_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_ack_i
);
	initial begin
		reg_req_o = 1'b0;
		reg_cmd_o = '0;
	end

	task automatic access(input logic we, input logic [7:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata, output logic ack);
		@(posedge sys_clk_i);
		#1;
		reg_cmd_o = '{we: we, addr: addr, wdata: wdata};
		reg_req_o = 1'b1;
		@(posedge sys_clk_i);
		#1;
		reg_req_o = 1'b0;
		// released command shows junk, not the last value
		reg_cmd_o = ~reg_cmd_o;
		rdata = reg_rdata_i;
		ack = reg_ack_i;
	endtask : access

	task automatic urow_done(output logic ack);
		logic [7:0] rd;
		// keeps the clock request bit up
		access(1'b1, DSA_OFS_CTRL, 8'h03, rd, ack);
	endtask : urow_done
endmodule : dsa_dbg_model

// ==== dsa_pkg.sv ====
// Purpose: constants and carrier types for the system access register group
// Assumes: 8-bit registers reached only through the debug link access port
// Notes: offsets are the access layer addresses of the three registers
package dsa_pkg;

	// register addresses
	localparam logic [7:0] DSA_OFS_CTRL = 8'h0A;
	localparam logic [7:0] DSA_OFS_STATUS = 8'h0B;
	localparam logic [7:0] DSA_OFS_CRC = 8'h0C;

	// control register fields
	localparam int DSA_CTRL_CLK_REQ_BIT = 0;
	localparam int DSA_CTRL_UROW_DONE_BIT = 1;

	// status register fields
	localparam int DSA_ST_LOCKED_BIT = 0;
	localparam int DSA_ST_UROWRDY_BIT = 2;
	localparam int DSA_ST_NVMRDY_BIT = 3;
	localparam int DSA_ST_SLEEP_BIT = 4;
	localparam int DSA_ST_SYS_RST_BIT = 5;
	localparam int DSA_ST_ERASE_FAIL_BIT = 6;

	// reset values
	localparam logic [7:0] DSA_CTRL_RST = 8'h00;
	localparam logic [7:0] DSA_STATUS_RST = 8'h01;
	localparam logic [7:0] DSA_CRC_RST = 8'h00;
	localparam logic [7:0] DSA_RDATA_RST = 8'h00;

	// checksum run status codes, one-hot except off, which is zero
	localparam logic [2:0] DSA_CRC_OFF = 3'h0;
	localparam logic [2:0] DSA_CRC_BUSY = 3'h1;
	localparam logic [2:0] DSA_CRC_PASS = 3'h2;
	localparam logic [2:0] DSA_CRC_FAIL = 3'h4;

	// system domain status, crosses into this clock
	typedef struct packed {
		logic in_reset;
		logic sleeping;
		logic nvm_ready;
		logic urow_ready;
		logic locked;
		logic erase_fail;
		logic crc_en;
		logic crc_busy;
		logic crc_pass;
		logic crc_fail;
	} dsa_sys_in_t;

	localparam int DSA_SYS_IN_W = 10;
	// locked after reset, everything else idle
	localparam logic [DSA_SYS_IN_W-1:0] DSA_SYS_IN_RST = 10'h020;

	// one access from the debug link
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dsa_reg_req_t;

endpackage : dsa_pkg

// ==== dsa_sync3.sv ====
// Purpose: three-stage synchroniser with agreement filter for a bundle
// Assumes: each bit is an independent slow level
// Notes: output takes a change once stages two and three agree
`timescale 1ns/100ps
module dsa_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// async levels in, filtered levels out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
	logic [W-1:0] q_next;

	// first stage feeds only the second
	always_comb begin
		q_next = q_reg;
		for (int i = 0; i < W; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				q_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			s1_reg <= RST;
			s2_reg <= RST;
			s3_reg <= RST;
			q_reg <= RST;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg <= q_next;
		end
	end

	assign q_o = q_reg;

endmodule : dsa_sync3

// ==== dsa_sys_access.sv ====
// Purpose: system access control, status and checksum status registers
// Assumes: the access layer issues one-cycle requests on the debug link port
// Notes: status inputs live in the system domain and are synchronised here
// Function
// - done bit with key starts user row programming
// - start proceeds even without data in RAM
// - done bit writes ignored without user row key
// - clock request bit set requests system clock
// - clock request bit cleared withdraws request
// - enabling debug interface sets clock request
// - erase failure sets bit six, reset clears
// - bit five shows system reset, read clears
// - held debug reset acts on both bits
// - bit four shows system sleeping
// - bit three shows NVM programming ready
// - bit two shows user row programming ready
// - bit zero shows device locked
// - checksum status codes are one-hot while enabled
// - checksum status zero when not enabled
// - registers reachable only over debug link
`timescale 1ns/100ps
module dsa_sys_access import dsa_pkg::*; (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// debug link register access
	input wire logic reg_req_i,
	input wire dsa_reg_req_t reg_cmd_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_ack_o,
	// debug interface state
	input wire logic dbg_enable_i,
	input wire logic urow_key_ok_i,
	input wire logic dbg_reset_hold_i,
	// system domain status
	input wire dsa_sys_in_t sys_stat_i,
	// requests towards the system
	output logic sys_clk_req_o,
	output logic urow_prog_start_o
);

	logic [DSA_SYS_IN_W-1:0] sys_q_vec;
	dsa_sys_in_t sys_q;

	logic wr_ctrl;
	logic rd_req;
	logic rd_status;
	logic rd_crc;
	logic erase_rise;

	logic erase_prev_reg, erase_prev_next;
	logic en_prev_reg, en_prev_next;
	logic erase_failed_reg, erase_failed_next;
	logic sys_rst_reg, sys_rst_next;
	logic clk_req_reg, clk_req_next;
	logic urow_start_reg, urow_start_next;
	logic [7:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;

	logic [7:0] ctrl_view;
	logic [7:0] status_view;
	logic [7:0] crc_view;
	logic [2:0] crc_code;

	// system levels are asynchronous here
	dsa_sync3 #(
		.W(DSA_SYS_IN_W),
		.RST(DSA_SYS_IN_RST)
	) u_sync (
		.clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.d_i(sys_stat_i),
		.q_o(sys_q_vec)
	);

	assign sys_q = sys_q_vec;

	// debug link decode only
	// there is no cpu-side port at all
	assign rd_req = reg_req_i && !reg_cmd_i.we;
	assign wr_ctrl = reg_req_i && reg_cmd_i.we && (reg_cmd_i.addr == DSA_OFS_CTRL);
	assign rd_status = rd_req && (reg_cmd_i.addr == DSA_OFS_STATUS);
	assign rd_crc = rd_req && (reg_cmd_i.addr == DSA_OFS_CRC);
	assign erase_rise = sys_q.erase_fail && !erase_prev_reg;

	// erase failure flag
	// held debug reset counts as a reset of the flag
	always_comb begin
		erase_prev_next = sys_q.erase_fail;
		erase_failed_next = erase_failed_reg;
		if (dbg_reset_hold_i) begin
			erase_failed_next = 1'b0;
		end else if (erase_rise) begin
			erase_failed_next = 1'b1;
		end
	end

	// system reset flag
	// set wins over the clear-on-read in the same cycle
	always_comb begin
		sys_rst_next = sys_rst_reg;
		if (sys_q.in_reset || dbg_reset_hold_i) begin
			sys_rst_next = 1'b1;
		end else if (rd_status) begin
			sys_rst_next = 1'b0;
		end
	end

	// system clock request
	// disable drops the request; enable edge beats a write
	always_comb begin
		en_prev_next = dbg_enable_i;
		clk_req_next = clk_req_reg;
		if (!dbg_enable_i) begin
			clk_req_next = 1'b0;
		end else if (!en_prev_reg) begin
			clk_req_next = 1'b1;
		end else if (wr_ctrl) begin
			clk_req_next = reg_cmd_i.wdata[DSA_CTRL_CLK_REQ_BIT];
		end
	end

	// user row done
	// no check on RAM contents: an early write starts anyway
	always_comb begin
		urow_start_next = wr_ctrl && urow_key_ok_i
			&& reg_cmd_i.wdata[DSA_CTRL_UROW_DONE_BIT];
	end

	// checksum one-hot encode
	// enabled but neither done nor busy is shown as busy
	always_comb begin
		if (!sys_q.crc_en) begin
			crc_code = DSA_CRC_OFF;
		end else if (sys_q.crc_busy) begin
			crc_code = DSA_CRC_BUSY;
		end else if (sys_q.crc_fail) begin
			crc_code = DSA_CRC_FAIL;
		end else if (sys_q.crc_pass) begin
			crc_code = DSA_CRC_PASS;
		end else begin
			crc_code = DSA_CRC_BUSY;
		end
	end

	// read views
	// done bit is write-only and reads zero
	always_comb begin
		ctrl_view = DSA_CTRL_RST;
		ctrl_view[DSA_CTRL_CLK_REQ_BIT] = clk_req_reg;
		status_view = 8'h00;
		status_view[DSA_ST_LOCKED_BIT] = sys_q.locked;
		status_view[DSA_ST_UROWRDY_BIT] = sys_q.urow_ready;
		status_view[DSA_ST_NVMRDY_BIT] = sys_q.nvm_ready;
		status_view[DSA_ST_SLEEP_BIT] = sys_q.sleeping;
		status_view[DSA_ST_SYS_RST_BIT] = sys_rst_reg;
		status_view[DSA_ST_ERASE_FAIL_BIT] = erase_failed_reg;
		crc_view = {5'h00, crc_code};
	end

	always_comb begin
		ack_next = reg_req_i;
		rdata_next = 8'h00;
		if (rd_req) begin
			unique case (reg_cmd_i.addr)
				DSA_OFS_CTRL: rdata_next = ctrl_view;
				DSA_OFS_STATUS: rdata_next = status_view;
				DSA_OFS_CRC: rdata_next = crc_view;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			erase_prev_reg <= 1'b0;
			en_prev_reg <= 1'b0;
			erase_failed_reg <= 1'b0;
			sys_rst_reg <= 1'b0;
			clk_req_reg <= DSA_CTRL_RST[DSA_CTRL_CLK_REQ_BIT];
			urow_start_reg <= 1'b0;
			rdata_reg <= DSA_RDATA_RST;
			ack_reg <= 1'b0;
		end else begin
			erase_prev_reg <= erase_prev_next;
			en_prev_reg <= en_prev_next;
			erase_failed_reg <= erase_failed_next;
			sys_rst_reg <= sys_rst_next;
			clk_req_reg <= clk_req_next;
			urow_start_reg <= urow_start_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_ack_o = ack_reg;
	assign sys_clk_req_o = clk_req_reg;
	assign urow_prog_start_o = urow_start_reg;

	// checks on the register behaviour

	a_urow_start_key: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_ctrl && urow_key_ok_i && reg_cmd_i.wdata[DSA_CTRL_UROW_DONE_BIT]
		|=> urow_prog_start_o ##1 (urow_prog_start_o
		== ($past(wr_ctrl) && $past(urow_key_ok_i)
		&& $past(reg_cmd_i.wdata[DSA_CTRL_UROW_DONE_BIT]))))
		else $error("user row start did not pulse after keyed write");

	a_urow_cause: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		urow_prog_start_o |-> $past(wr_ctrl) && $past(urow_key_ok_i))
		else $error("user row start without keyed control write");

	a_urow_no_key: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_ctrl && !urow_key_ok_i |=> !urow_prog_start_o)
		else $error("user row start despite missing key");

	a_clk_req_set: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		dbg_enable_i && en_prev_reg && wr_ctrl
		&& reg_cmd_i.wdata[DSA_CTRL_CLK_REQ_BIT] |=> sys_clk_req_o)
		else $error("clock request not raised by write of one");

	a_clk_req_clear: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		dbg_enable_i && en_prev_reg && wr_ctrl
		&& !reg_cmd_i.wdata[DSA_CTRL_CLK_REQ_BIT] |=> !sys_clk_req_o)
		else $error("clock request not lowered by write of zero");

	a_clk_req_enable: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		$rose(dbg_enable_i) |=> sys_clk_req_o)
		else $error("clock request not set on enable");

	a_erase_set: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		erase_rise && !dbg_reset_hold_i
		##1 (!dbg_reset_hold_i && rd_status) |=> reg_rdata_o[DSA_ST_ERASE_FAIL_BIT])
		else $error("erase failure not reported");

	a_sys_rst_show: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		sys_q.in_reset ##1 rd_status |=> reg_rdata_o[DSA_ST_SYS_RST_BIT])
		else $error("system reset not reported while active");

	a_sys_rst_rdclr: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_status && !sys_q.in_reset && !dbg_reset_hold_i |=> !sys_rst_reg)
		else $error("system reset flag not cleared by read");

	a_hold_effect: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		dbg_reset_hold_i |=> !erase_failed_reg && sys_rst_reg)
		else $error("held debug reset did not act on status bits");

	a_status_lvls: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_status |=> reg_ack_o
		&& reg_rdata_o[DSA_ST_SLEEP_BIT] == $past(sys_q.sleeping)
		&& reg_rdata_o[DSA_ST_NVMRDY_BIT] == $past(sys_q.nvm_ready))
		else $error("sleep or NVM ready bit wrong on read");

	a_nvm_ready: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_status && sys_q.nvm_ready |=> reg_rdata_o[DSA_ST_NVMRDY_BIT])
		else $error("NVM ready not shown");

	a_urow_ready: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_status |=> reg_rdata_o[DSA_ST_UROWRDY_BIT] == $past(sys_q.urow_ready))
		else $error("user row ready bit wrong on read");

	a_lock_show: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_status |=> reg_rdata_o[DSA_ST_LOCKED_BIT] == $past(sys_q.locked))
		else $error("lock bit wrong on read");

	a_crc_onehot: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_crc && sys_q.crc_en |=> $onehot(reg_rdata_o[2:0]))
		else $error("checksum status not one-hot while enabled");

	a_crc_off: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_crc && !sys_q.crc_en |=> reg_rdata_o == 8'h00)
		else $error("checksum status not zero while disabled");

	a_reserved_zero: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		reg_ack_o |-> !reg_rdata_o[7] && ($past(rd_status) ? !reg_rdata_o[1]
		: reg_rdata_o[7:3] == 5'h00))
		else $error("reserved bits not zero on read");

	c_urow_start: cover property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		urow_prog_start_o);

	c_clk_req_enable: cover property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		$rose(dbg_enable_i) ##1 sys_clk_req_o);

	c_erase_fail: cover property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		$rose(erase_failed_reg));

	c_sys_rst_clear: cover property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		sys_rst_reg ##1 rd_status ##1 !sys_rst_reg);

endmodule : dsa_sys_access

// ==== tb_top.sv ====
// Purpose: self-checking bench of the system access register group
// Assumes: all inputs move 1 ns after the rising edge
// Notes: status inputs need 4 edges to land, the bench allows 6
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top import dsa_pkg::*;;
	logic sys_clk_i;
	logic rstn_i;
	logic reg_req;
	dsa_reg_req_t reg_cmd;
	logic [7:0] reg_rdata;
	logic reg_ack;
	logic dbg_enable_i;
	logic urow_key_ok_i;
	logic dbg_reset_hold_i;
	dsa_sys_in_t sys_stat_i;
	logic sys_clk_req;
	logic urow_start;
	int num_errors = 0;
	int samples_checked = 0;
	logic [7:0] rd;
	logic ack;
	logic [3:0] crc_in [5] = '{4'h0, 4'hC, 4'hA, 4'h9, 4'h8};
	logic [7:0] crc_exp [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h01};

	dsa_sys_access u_dsa_sys_access (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_req_i(reg_req), .reg_cmd_i(reg_cmd),
		.reg_rdata_o(reg_rdata), .reg_ack_o(reg_ack), .dbg_enable_i(dbg_enable_i),
		.urow_key_ok_i(urow_key_ok_i), .dbg_reset_hold_i(dbg_reset_hold_i),
		.sys_stat_i(sys_stat_i), .sys_clk_req_o(sys_clk_req), .urow_prog_start_o(urow_start));
	dsa_dbg_model u_dsa_dbg_model (
		.sys_clk_i(sys_clk_i), .reg_req_o(reg_req), .reg_cmd_o(reg_cmd),
		.reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack));

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
		u_dsa_dbg_model.access(1'b0, addr, 8'h00, rd, ack);
		`CHK(ack, 1'b1)
		`CHK(rd, exp)
	endtask : rd_chk

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		u_dsa_dbg_model.access(1'b1, addr, data, rd, ack);
		`CHK(ack, 1'b1)
	endtask : wr

	task automatic settle();
		repeat (6) @(posedge sys_clk_i);
		#1;
	endtask : settle

	task automatic t_reset();
		rd_chk(DSA_OFS_CTRL, 8'h00);
		rd_chk(DSA_OFS_STATUS, 8'h01);
		rd_chk(DSA_OFS_CRC, 8'h00);
		rd_chk(8'h00, 8'h00);
	endtask : t_reset

	task automatic t_clk_req();
		@(posedge sys_clk_i);
		#1;
		dbg_enable_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		`CHK(sys_clk_req, 1'b1)
		wr(DSA_OFS_CTRL, 8'h00);
		`CHK(sys_clk_req, 1'b0)
		wr(DSA_OFS_CTRL, 8'hFF);
		`CHK(sys_clk_req, 1'b1)
		`CHK(urow_start, 1'b0)
		rd_chk(DSA_OFS_CTRL, 8'h01);
	endtask : t_clk_req

	task automatic t_urow();
		wr(DSA_OFS_CTRL, 8'h03);
		`CHK(urow_start, 1'b0)
		urow_key_ok_i = 1'b1;
		// no data was loaded, the start must still fire
		u_dsa_dbg_model.urow_done(ack);
		`CHK(urow_start, 1'b1)
		@(posedge sys_clk_i);
		#1;
		`CHK(urow_start, 1'b0)
		urow_key_ok_i = 1'b0;
	endtask : t_urow

	task automatic t_status();
		sys_stat_i = '{sleeping: 1'b1, nvm_ready: 1'b1, urow_ready: 1'b1, default: 1'b0};
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h1C);
		sys_stat_i.sleeping = 1'b0;
		sys_stat_i.locked = 1'b1;
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h0D);
		wr(DSA_OFS_STATUS, 8'hFF);
		rd_chk(DSA_OFS_STATUS, 8'h0D);
	endtask : t_status

	task automatic t_flags();
		sys_stat_i = '0;
		sys_stat_i.erase_fail = 1'b1;
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h40);
		sys_stat_i.in_reset = 1'b1;
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h60);
		sys_stat_i.in_reset = 1'b0;
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h60);
		rd_chk(DSA_OFS_STATUS, 8'h40);
		dbg_reset_hold_i = 1'b1;
		rd_chk(DSA_OFS_STATUS, 8'h20);
		dbg_reset_hold_i = 1'b0;
		rd_chk(DSA_OFS_STATUS, 8'h20);
		rd_chk(DSA_OFS_STATUS, 8'h00);
	endtask : t_flags

	task automatic t_crc();
		for (int i = 0; i < 5; i++) begin
			{sys_stat_i.crc_en, sys_stat_i.crc_busy, sys_stat_i.crc_pass,
				sys_stat_i.crc_fail} = crc_in[i];
			settle();
			rd_chk(DSA_OFS_CRC, crc_exp[i]);
		end
		wr(DSA_OFS_CRC, 8'hFF);
		rd_chk(DSA_OFS_CRC, 8'h01);
	endtask : t_crc

	task automatic t_rst_mid();
		// fresh erase failure, sticky after its source drops
		sys_stat_i.erase_fail = 1'b0;
		settle();
		sys_stat_i.erase_fail = 1'b1;
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h40);
		sys_stat_i.erase_fail = 1'b0;
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h40);
		// mid-run reset with the interface left enabled
		rstn_i = 1'b0;
		repeat (12) @(posedge sys_clk_i);
		#1;
		rstn_i = 1'b1;
		`CHK(sys_clk_req, 1'b0)
		rd_chk(DSA_OFS_CTRL, 8'h01);
		settle();
		rd_chk(DSA_OFS_STATUS, 8'h00);
		// a second enable edge must raise the request again
		dbg_enable_i = 1'b0;
		@(posedge sys_clk_i);
		#1;
		`CHK(sys_clk_req, 1'b0)
		dbg_enable_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		`CHK(sys_clk_req, 1'b1)
	endtask : t_rst_mid

	initial begin
		rstn_i = 1'b0;
		dbg_enable_i = 1'b0;
		urow_key_ok_i = 1'b0;
		dbg_reset_hold_i = 1'b0;
		sys_stat_i = DSA_SYS_IN_RST;
		repeat (12) @(posedge sys_clk_i);
		#1;
		rstn_i = 1'b1;
		t_reset();
		t_clk_req();
		t_urow();
		t_status();
		t_flags();
		t_crc();
		t_rst_mid();
		summarize();
	end

	// hang guard
	initial begin
		#40000;
		num_errors++;
		$display("CHECK FAILED t=%0t run limit reached", $time);
		summarize();
	end
endmodule : tb_top
